/* rtl/fis_host.sv */
// Host-side sequencer that issues flash instruction sequences on the pins.
// Assumes a flash with the documented command interface on the far side.
`timescale 1ns/1ps
`include "fis_defines.svh"

// Notes on behaviour
// - Auto-select is unlock pair then 90h; reads follow.
// - Program is unlock pair, A0h, then address with data; then poll.
// - Block erase is unlock, 80h, unlock, 30h at block address.
// - Added blocks take 30h at block address before erase timeout expires; host sends it regardless, flagging op_timeout_hit from the last poll.
// - Chip erase is unlock, 80h, unlock, 10h; then poll.
// - B0h suspends erase, 30h resumes it; then poll.
// - Host detects erase completion by polling the toggle bit until two reads agree; ready/busy is not used.
// - After reset during program or erase, host waits recovery delay.
// - Unlock pair is AAh at AAAAh, 55h at 5555h; word mode differs.
module fis_host
  import fis_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire fis_op_t cmd_op,
  input wire logic cmd_short_reset,
  input wire logic word_mode,
  input wire logic [17:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  output logic cmd_ready,
  output logic op_done,
  output logic op_error,
  output logic op_timeout_hit,
  input wire logic rd_valid,
  input wire logic [17:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_done,
  output logic chip_en_n,
  output logic out_en_n,
  output logic write_en_n,
  output logic [17:0] addr_pin,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in,
  input wire logic ready_busy_out
);
  typedef enum logic [2:0] {S_IDLE, S_WRITE, S_POLL, S_READ, S_RECOVER} fis_st_t;
  typedef struct packed {
    fis_st_t st;
    fis_op_t op;
    logic [2:0] step;
    logic [2:0] last;
    logic [17:0] addr;
    logic [15:0] data;
    logic word;
    logic was_busy;
    logic req;
    logic [15:0] cnt;
    logic [15:0] prev;
    logic first_poll;
    logic ready;
    logic done;
    logic err;
    logic tmo;
    logic [15:0] rdata;
    logic rdone;
    logic user_rd;
    logic rb1;
    logic rb2;
    logic rb3;
  } fis_host_t;
  fis_host_t st_r, st_nxt;
  fis_bus_if bus();

  fis_pin_engine u_eng (
    .mclk(mclk),
    .reset(reset),
    .bus(bus),
    .chip_en_n(chip_en_n),
    .out_en_n(out_en_n),
    .write_en_n(write_en_n),
    .addr_pin(addr_pin),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .dq_in(dq_in)
  );

  // Address of one of the two unlock cycles, by bus width
  function automatic logic [17:0] unlock_addr(input logic word, input logic second);
    if (word) begin
      unlock_addr = second ? `FIS_ADDR_WORD_U2 : `FIS_ADDR_WORD_U1;
    end else begin
      unlock_addr = second ? `FIS_ADDR_BYTE_U2 : `FIS_ADDR_BYTE_U1;
    end
  endfunction

  // Address and data of write cycle n of an instruction
  function automatic logic [33:0] step_cycle(input fis_op_t op, input logic [2:0] n,
                                             input logic word, input logic [17:0] a,
                                             input logic [15:0] d);
    logic [7:0] code;
    code = `FIS_CMD_RESET;
    unique case (op)
      FIS_OP_RESET: code = `FIS_CMD_RESET;
      FIS_OP_AUTOSEL: code = `FIS_CMD_AUTOSEL;
      FIS_OP_PROGRAM: code = `FIS_CMD_PROGRAM;
      FIS_OP_BLOCK_ERASE, FIS_OP_CHIP_ERASE: code = `FIS_CMD_SETUP_ERASE;
      FIS_OP_ADD_BLOCK: code = `FIS_CMD_BLOCK_ERASE;
      FIS_OP_SUSPEND: code = `FIS_CMD_SUSPEND;
      FIS_OP_RESUME: code = `FIS_CMD_RESUME;
    endcase
    if (n == 3'd0 || n == 3'd3) begin
      step_cycle = {unlock_addr(word, 1'b0), 8'h00, `FIS_CMD_UNLOCK1};
    end else if (n == 3'd1 || n == 3'd4) begin
      step_cycle = {unlock_addr(word, 1'b1), 8'h00, `FIS_CMD_UNLOCK2};
    end else if (n == 3'd2) begin
      step_cycle = {unlock_addr(word, 1'b0), 8'h00, code};
    end else if (n == 3'd6) begin
      step_cycle = {a, d};
    end else if (op == FIS_OP_SUSPEND) begin
      step_cycle = {a, 8'h00, `FIS_CMD_SUSPEND};
    end else if (op == FIS_OP_CHIP_ERASE) begin
      step_cycle = {unlock_addr(word, 1'b0), 8'h00, `FIS_CMD_CHIP_ERASE};
    end else begin
      step_cycle = {a, 8'h00, `FIS_CMD_BLOCK_ERASE};
    end
  endfunction

  // ------------------------------------------------
  // Sequencer
  // ------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.rdone = 1'b0;
    st_nxt.req = 1'b0;
    st_nxt.rb1 = ready_busy_out;
    st_nxt.rb2 = st_r.rb1;
    st_nxt.rb3 = st_r.rb2;
    unique case (st_r.st)
      S_IDLE: begin
        if (cmd_valid && st_r.ready) begin
          st_nxt.ready = 1'b0;
          st_nxt.op = cmd_op;
          st_nxt.addr = cmd_addr;
          st_nxt.data = cmd_data;
          st_nxt.word = word_mode;
          st_nxt.err = 1'b0;
          st_nxt.tmo = 1'b0;
          st_nxt.st = S_WRITE;
          st_nxt.req = 1'b1;
          st_nxt.last = 3'd2;
          st_nxt.step = 3'd0;
          unique case (cmd_op)
            FIS_OP_RESET: begin
              st_nxt.was_busy = !(st_r.rb2 && st_r.rb3);
              if (cmd_short_reset) begin
                st_nxt.step = 3'd2;
              end
            end
            FIS_OP_SUSPEND, FIS_OP_RESUME, FIS_OP_ADD_BLOCK: st_nxt.step = 3'd5;
            FIS_OP_PROGRAM: st_nxt.last = 3'd6;
            FIS_OP_BLOCK_ERASE, FIS_OP_CHIP_ERASE: st_nxt.last = 3'd5;
            default: st_nxt.last = 3'd2;
          endcase
          if (cmd_op inside {FIS_OP_SUSPEND, FIS_OP_RESUME, FIS_OP_ADD_BLOCK}) begin
            st_nxt.last = 3'd5;
          end
        end else if (rd_valid && st_r.ready) begin
          // Plain reads rely on the device staying in its current read mode
          st_nxt.ready = 1'b0;
          st_nxt.addr = rd_addr;
          st_nxt.user_rd = 1'b1;
          st_nxt.st = S_READ;
          st_nxt.req = 1'b1;
        end
      end
      S_WRITE: begin
        if (bus.done) begin
          if (st_r.step == st_r.last) begin
            if (st_r.op == FIS_OP_ADD_BLOCK && st_r.prev[`FIS_BIT_ETIMER]) begin
              st_nxt.tmo = 1'b1;
            end
            if (st_r.op == FIS_OP_RESET && st_r.was_busy) begin
              st_nxt.st = S_RECOVER;
              st_nxt.cnt = '0;
            end else if (st_r.op inside {FIS_OP_PROGRAM, FIS_OP_BLOCK_ERASE,
                                         FIS_OP_CHIP_ERASE, FIS_OP_RESUME}) begin
              st_nxt.st = S_POLL;
              st_nxt.first_poll = 1'b1;
              st_nxt.req = 1'b1;
            end else begin
              st_nxt.st = S_IDLE;
              st_nxt.done = 1'b1;
              st_nxt.ready = 1'b1;
            end
          end else begin
            st_nxt.step = (st_r.op == FIS_OP_PROGRAM && st_r.step == 3'd2) ? 3'd6 :
                          st_r.step + 3'd1;
            st_nxt.req = 1'b1;
          end
        end
      end
      S_POLL: begin
        // Toggle bit settles when two reads agree; the ready/busy pin alone is not trusted
        if (bus.done) begin
          st_nxt.prev = bus.rdata;
          st_nxt.first_poll = 1'b0;
          if (!st_r.first_poll && bus.rdata[`FIS_BIT_TOGGLE] == st_r.prev[`FIS_BIT_TOGGLE]) begin
            st_nxt.st = S_IDLE;
            st_nxt.done = 1'b1;
            st_nxt.ready = 1'b1;
          end else if (bus.rdata[`FIS_BIT_ERROR] && !st_r.first_poll) begin
            st_nxt.err = 1'b1;
            st_nxt.st = S_IDLE;
            st_nxt.done = 1'b1;
            st_nxt.ready = 1'b1;
          end else begin
            st_nxt.req = 1'b1;
          end
        end
      end
      S_READ: begin
        if (bus.done) begin
          // Array data must not stand in for the last status word
          st_nxt.rdata = bus.rdata;
          st_nxt.rdone = 1'b1;
          st_nxt.user_rd = 1'b0;
          st_nxt.st = S_IDLE;
          st_nxt.ready = 1'b1;
        end
      end
      S_RECOVER: begin
        st_nxt.cnt = st_r.cnt + 16'h1;
        if (st_r.cnt == 16'(`FIS_T_RECOVER_CYC - 1)) begin
          st_nxt.st = S_IDLE;
          st_nxt.done = 1'b1;
          st_nxt.ready = 1'b1;
        end
      end
    endcase
    if (st_nxt.st == S_POLL || st_nxt.st == S_READ) begin
      st_nxt.addr = (st_nxt.st == S_READ) ? st_nxt.addr : st_r.addr;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '{st: S_IDLE, op: FIS_OP_RESET, step: 3'd0, last: 3'd0, addr: 18'h0,
                data: 16'h0, word: 1'b0, was_busy: 1'b0, req: 1'b0, cnt: 16'h0,
                prev: 16'h0, first_poll: 1'b0, ready: 1'b1, done: 1'b0, err: 1'b0,
                tmo: 1'b0, rdata: 16'h0, rdone: 1'b0, user_rd: 1'b0,
                rb1: 1'b1, rb2: 1'b1, rb3: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    logic [33:0] c;
    c = step_cycle(st_r.op, st_r.step, st_r.word, st_r.addr, st_r.data);
    bus.req = st_r.req;
    bus.kind = (st_r.st == S_WRITE) ? FIS_CYC_WRITE : FIS_CYC_READ;
    bus.addr = (st_r.st == S_WRITE) ? c[33:16] : st_r.addr;
    bus.wdata = c[15:0];
  end

  assign cmd_ready = st_r.ready;
  assign op_done = st_r.done;
  assign op_error = st_r.err;
  assign op_timeout_hit = st_r.tmo;
  assign rd_data = st_r.rdata;
  assign rd_done = st_r.rdone;

  a_reset_recover_len: assert property (@(posedge mclk) disable iff (reset)
    $rose(st_r.st == S_RECOVER) |-> (st_r.st == S_RECOVER) [*8] ##[1:20] op_done)
    else $error("recovery wait too short");
  a_program_code: assert property (@(posedge mclk) disable iff (reset)
    (st_r.st == S_WRITE && st_r.op == FIS_OP_PROGRAM && st_r.step == 3'd2 && st_r.req)
    |-> bus.wdata[7:0] == 8'ha0) else $error("program code wrong");
  a_unlock_first: assert property (@(posedge mclk) disable iff (reset)
    (st_r.st == S_WRITE && st_r.req && st_r.step == 3'd0)
    |-> bus.wdata[7:0] == 8'haa && bus.addr[14:0] == (st_r.word ? 15'h5555 : 15'h2aaa))
    else $error("first unlock wrong");
  a_unlock_second: assert property (@(posedge mclk) disable iff (reset)
    (st_r.st == S_WRITE && st_r.req && st_r.step == 3'd4) |-> bus.wdata[7:0] == 8'h55)
    else $error("second unlock wrong");
  a_chip_erase_code: assert property (@(posedge mclk) disable iff (reset)
    (st_r.st == S_WRITE && st_r.op == FIS_OP_CHIP_ERASE && st_r.step == 3'd5 && st_r.req)
    |-> bus.wdata[7:0] == 8'h10) else $error("chip erase code wrong");
  a_block_erase_code: assert property (@(posedge mclk) disable iff (reset)
    (st_r.st == S_WRITE && st_r.op == FIS_OP_BLOCK_ERASE && st_r.step == 3'd5 && st_r.req)
    |-> bus.wdata[7:0] == 8'h30 && bus.addr == st_r.addr) else $error("block erase wrong");
  a_suspend_single: assert property (@(posedge mclk) disable iff (reset)
    (st_r.st == S_WRITE && st_r.op == FIS_OP_SUSPEND && st_r.req)
    |-> st_r.step == 3'd5 && bus.wdata[7:0] == 8'hb0) else $error("suspend not single");
  a_short_reset: assert property (@(posedge mclk) disable iff (reset)
    (cmd_valid && cmd_ready && cmd_op == FIS_OP_RESET && cmd_short_reset)
    |=> st_r.step == 3'd2 ##0 bus.wdata[7:0] == 8'hf0) else $error("short reset wrong");
  a_autosel_code: assert property (@(posedge mclk) disable iff (reset)
    (st_r.st == S_WRITE && st_r.op == FIS_OP_AUTOSEL && st_r.step == 3'd2 && st_r.req)
    |-> bus.wdata[7:0] == 8'h90) else $error("auto-select code wrong");
  c_program: cover property (@(posedge mclk) st_r.op == FIS_OP_PROGRAM && op_done);
  c_chip_erase: cover property (@(posedge mclk) st_r.op == FIS_OP_CHIP_ERASE && op_done);
  c_recover: cover property (@(posedge mclk) st_r.st == S_RECOVER);
  c_read: cover property (@(posedge mclk) rd_done);
endmodule

/* rtl/fis_defines.svh */
// Command codes, unlock addresses, status bit positions and timing counts.
// Assumes a 25 MHz mclk; included by the fis_host and fis_pin_engine design files.
`ifndef FIS_DEFINES_SVH
`define FIS_DEFINES_SVH
`define FIS_CMD_UNLOCK1 8'haa
`define FIS_CMD_UNLOCK2 8'h55
`define FIS_CMD_RESET 8'hf0
`define FIS_CMD_AUTOSEL 8'h90
`define FIS_CMD_PROGRAM 8'ha0
`define FIS_CMD_SETUP_ERASE 8'h80
`define FIS_CMD_BLOCK_ERASE 8'h30
`define FIS_CMD_CHIP_ERASE 8'h10
`define FIS_CMD_SUSPEND 8'hb0
`define FIS_CMD_RESUME 8'h30
`define FIS_ADDR_BYTE_U1 18'h2aaaa
`define FIS_ADDR_BYTE_U2 18'h15555
`define FIS_ADDR_WORD_U1 18'h15555
`define FIS_ADDR_WORD_U2 18'h12aaa
`define FIS_BIT_POLL 7
`define FIS_BIT_TOGGLE 6
`define FIS_BIT_ERROR 5
`define FIS_BIT_ETIMER 3
`define FIS_CLK_NS 40
`define FIS_T_WE_NS 80
`define FIS_T_WE_CYC ((`FIS_T_WE_NS + `FIS_CLK_NS - 1) / `FIS_CLK_NS)
`define FIS_T_RD_NS 120
`define FIS_T_RD_CYC ((`FIS_T_RD_NS + `FIS_CLK_NS - 1) / `FIS_CLK_NS)
`define FIS_T_RECOVER_NS 500
`define FIS_T_RECOVER_CYC ((`FIS_T_RECOVER_NS + `FIS_CLK_NS - 1) / `FIS_CLK_NS)
`endif

/* rtl/fis_pkg.sv */
// Types shared by the flash command host modules.
// Assumes fis_defines.svh is available on the include path.
package fis_pkg;
  typedef enum logic [2:0] {
    FIS_OP_RESET,
    FIS_OP_AUTOSEL,
    FIS_OP_PROGRAM,
    FIS_OP_BLOCK_ERASE,
    FIS_OP_ADD_BLOCK,
    FIS_OP_CHIP_ERASE,
    FIS_OP_SUSPEND,
    FIS_OP_RESUME
  } fis_op_t;
  typedef enum logic [1:0] {
    FIS_CYC_IDLE,
    FIS_CYC_WRITE,
    FIS_CYC_READ
  } fis_cyc_t;
endpackage

/* rtl/fis_bus_if.sv */
// Carries one bus cycle request between the sequencer and the pin engine.
// Assumes both ends share mclk.
`timescale 1ns/1ps
interface fis_bus_if;
  import fis_pkg::*;
  fis_cyc_t kind;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic req;
  logic done;
  modport seq (output kind, output addr, output wdata, output req, input rdata, input done);
  modport eng (input kind, input addr, input wdata, input req, output rdata, output done);
endinterface

/* rtl/fis_pin_engine.sv */
// Drives one write or read cycle on the flash pins.
// Assumes the flash is asynchronous; data input passes a 3-stage synchroniser.
`timescale 1ns/1ps
`include "fis_defines.svh"
module fis_pin_engine
  import fis_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  fis_bus_if.eng bus,
  output logic chip_en_n,
  output logic out_en_n,
  output logic write_en_n,
  output logic [17:0] addr_pin,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in
);
  typedef struct packed {
    logic busy;
    fis_cyc_t kind;
    logic [3:0] cnt;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [17:0] addr;
    logic [15:0] dout;
    logic doe;
    logic [15:0] rdata;
    logic done;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
  } fis_eng_t;
  fis_eng_t st_r, st_nxt;

  // ------------------------------------------------
  // Cycle timing
  // ------------------------------------------------
  // Read data is taken only when two late stages agree, so a bus still settling is not captured
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.s1 = dq_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (!st_r.busy) begin
      if (bus.req && bus.kind != FIS_CYC_IDLE) begin
        st_nxt.busy = 1'b1;
        st_nxt.kind = bus.kind;
        st_nxt.addr = bus.addr;
        st_nxt.dout = bus.wdata;
        st_nxt.ce_n = 1'b0;
        st_nxt.cnt = '0;
        if (bus.kind == FIS_CYC_WRITE) begin
          st_nxt.we_n = 1'b0;
          st_nxt.doe = 1'b1;
        end else begin
          st_nxt.oe_n = 1'b0;
        end
      end
    end else begin
      st_nxt.cnt = st_r.cnt + 4'h1;
      if (st_r.kind == FIS_CYC_WRITE && st_r.cnt == 4'(`FIS_T_WE_CYC - 1)) begin
        st_nxt.we_n = 1'b1;
      end else if (st_r.kind == FIS_CYC_WRITE && st_r.cnt == 4'(`FIS_T_WE_CYC)) begin
        st_nxt.ce_n = 1'b1;
        st_nxt.doe = 1'b0;
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else if (st_r.kind == FIS_CYC_READ && st_r.cnt >= 4'(`FIS_T_RD_CYC + 2)
                   && st_r.s2 == st_r.s3) begin
        st_nxt.rdata = st_r.s3;
        st_nxt.oe_n = 1'b1;
        st_nxt.ce_n = 1'b1;
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '{busy: 1'b0, kind: FIS_CYC_IDLE, cnt: 4'h0, ce_n: 1'b1, oe_n: 1'b1,
                we_n: 1'b1, addr: 18'h0, dout: 16'h0, doe: 1'b0, rdata: 16'h0,
                done: 1'b0, s1: 16'h0, s2: 16'h0, s3: 16'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.done = st_r.done;
  assign bus.rdata = st_r.rdata;
  assign chip_en_n = st_r.ce_n;
  assign out_en_n = st_r.oe_n;
  assign write_en_n = st_r.we_n;
  assign addr_pin = st_r.addr;
  assign dq_out = st_r.dout;
  assign dq_oe = st_r.doe;

  a_write_pulse_len: assert property (@(posedge mclk) disable iff (reset)
    $fell(write_en_n) |-> !write_en_n [*2] ##1 write_en_n)
    else $error("write strobe width wrong");
  a_no_drive_on_read: assert property (@(posedge mclk) disable iff (reset)
    !out_en_n |-> !dq_oe) else $error("data driven during read");
endmodule

/* tb/fis_flash_model.sv */
// Behavioural flash device answering the fis_host pin set.
// Assumes word_mode matches the host setting; testbench reads the write log.
`timescale 1ns/1ps
module fis_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h00a1, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h00b2 // Arbitrary value
) (
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic [17:0] addr_pin,
  input wire logic [15:0] dq_out,
  input wire logic word_mode,
  output logic [15:0] dq_in,
  output logic ready_busy_out
);
  logic [17:0] wa[$];
  logic [15:0] wd[$];
  logic [15:0] mem[logic [17:0]];
  logic [15:0] rv = 16'h0;
  logic [15:0] pd = 16'h0;
  logic [63:0] prot = 64'h20;
  logic [7:0] d;
  logic [5:0] eblk;
  int st = 0;
  int cnt = 0;
  int saved = 0;
  bit ers, asel, susp, tog, err_inj, erasing;

  function automatic bit ulk(logic [17:0] a, bit sec);
    return a[14:0] == ((word_mode ^ sec) ? 15'h5555 : 15'h2aaa);
  endfunction

  task automatic erase_blk(logic [5:0] b);
    foreach (mem[k]) if (k[17:12] == b) mem[k] = 16'hffff;
  endtask

  // ----------------------------------------
  // Command decoder, one step per write
  // ----------------------------------------
  always @(posedge write_en_n) begin
    if (!chip_en_n) begin
      wa.push_back(addr_pin);
      wd.push_back(dq_out);
      d = dq_out[7:0];
      if (st == 3) begin
        if (!(susp && addr_pin[17:12] == eblk)) mem[addr_pin] = dq_out;
        pd = dq_out;
        cnt = 3;
        erasing = 0;
        st = 0;
      end else if (st == 1 && d == 8'h55 && ulk(addr_pin, 1)) st = 2;
      else if (st == 2) begin
        st = 0;
        asel = !ers && d == 8'h90;
        if (ers && d == 8'h30) begin
          eblk = addr_pin[17:12];
          erase_blk(eblk);
          cnt = 4;
          erasing = 1;
        end else if (ers && d == 8'h10) begin
          foreach (mem[k]) mem[k] = 16'hffff;
          cnt = 5;
          erasing = 1;
        end else if (!ers && d == 8'ha0) st = 3;
        else if (d == 8'hf0) cnt = 0;
        ers = !ers && d == 8'h80;
      end else if (st == 0 && d == 8'haa && ulk(addr_pin, 0)) st = 1;
      else if (d == 8'hb0 && erasing && cnt > 0) begin
        susp = 1;
        saved = cnt;
        cnt = 0;
      end else if (d == 8'h30 && susp) begin
        susp = 0;
        cnt = saved;
      end else if (d == 8'h30 && erasing && cnt > 2) erase_blk(addr_pin[17:12]);
      else begin
        if (d == 8'hf0) cnt = 0;
        st = 0;
        ers = 0;
        asel = 0;
      end
    end
  end

  // ----------------------------------------
  // Read side
  // ----------------------------------------
  // Settle delay avoids racing the host's strobe updates
  always @(negedge out_en_n) begin
    #1;
    if (!chip_en_n) begin
      if (cnt > 0) begin
        tog = !tog;
        cnt--;
      end
      if (cnt > 0) rv = {8'h0, erasing ? 1'b0 : ~pd[7], tog, err_inj, 1'b0,
                         !(erasing && cnt > 2), 3'h0};
      else if (asel) rv = addr_pin[1] ? {15'h0, prot[addr_pin[17:12]]} :
                          (addr_pin[0] ? DEV_ID : MAKER_ID);
      else rv = mem.exists(addr_pin) ? mem[addr_pin] : 16'hffff;
    end
  end

  // No pull on the bus: released lines show the inverse
  assign dq_in = (!chip_en_n && !out_en_n) ? rv : ~rv;
  assign ready_busy_out = (cnt == 0);
endmodule

/* tb/testbench.sv */
// Self-checking bench driving fis_host against the flash model.
// Assumes rtl files compiled first; mclk at 25 MHz.
`timescale 1ns/1ps
`define CHK_EQ(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  import fis_pkg::*;
  logic mclk, reset, cmd_valid, cmd_short_reset, word_mode, rd_valid;
  fis_op_t cmd_op;
  logic [17:0] cmd_addr, rd_addr, addr_pin;
  logic [15:0] cmd_data, rd_data, dq_out, dq_in, got;
  logic cmd_ready, op_done, op_error, op_timeout_hit, rd_done;
  logic chip_en_n, out_en_n, write_en_n, dq_oe, ready_busy_out;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int lat;

  fis_host dut (.mclk, .reset, .cmd_valid, .cmd_op, .cmd_short_reset, .word_mode, .cmd_addr,
    .cmd_data, .cmd_ready, .op_done, .op_error, .op_timeout_hit, .rd_valid, .rd_addr,
    .rd_data, .rd_done, .chip_en_n, .out_en_n, .write_en_n, .addr_pin, .dq_out, .dq_oe,
    .dq_in, .ready_busy_out);
  fis_flash_model flash (.chip_en_n, .out_en_n, .write_en_n, .addr_pin, .dq_out,
    .word_mode, .dq_in, .ready_busy_out);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic test_done();
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic run(fis_op_t op, logic [17:0] a, logic [15:0] dat, logic sr);
    flash.wa.delete();
    flash.wd.delete();
    lat = 0;
    @(negedge mclk);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = dat;
    cmd_short_reset = sr;
    cmd_valid = 1'b1;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    @(negedge mclk);
    cmd_valid = 1'b0;
    while (op_done !== 1'b1 && lat < 3000) begin
      @(negedge mclk);
      lat++;
    end
    `CHK_EQ("op_done", 1'b1, op_done)
  endtask

  task automatic rd(logic [17:0] a);
    int n;
    n = 0;
    @(negedge mclk);
    rd_addr = a;
    rd_valid = 1'b1;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    @(negedge mclk);
    rd_valid = 1'b0;
    while (rd_done !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    `CHK_EQ("rd_done", 1'b1, rd_done)
    got = rd_data;
  endtask

  function automatic logic [17:0] u(bit s);
    return {3'h0, (word_mode ^ s) ? 15'h5555 : 15'h2aaa};
  endfunction

  task automatic wr(int i, logic [17:0] a, logic [7:0] dat);
    `CHK_EQ("wr_addr", a[14:0], flash.wa[i][14:0])
    `CHK_EQ("wr_data", dat, flash.wd[i][7:0])
  endtask

  task automatic ulp(int i);
    wr(i, u(0), 8'haa);
    wr(i + 1, u(1), 8'h55);
  endtask

  task automatic nwr(int n);
    `CHK_EQ("wr_count", n, flash.wa.size())
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK_EQ("cmd_ready", 1'b1, cmd_ready)
    `CHK_EQ("strobes", 3'h7, {chip_en_n, out_en_n, write_en_n})
    `CHK_EQ("dq_oe", 1'b0, dq_oe)
  endtask

  task automatic t_program();
    for (int w = 0; w < 2; w++) begin
      word_mode = w[0];
      run(FIS_OP_PROGRAM, 18'h00120 + 18'(w), 16'h5a3c ^ 16'(w), 1'b0);
      nwr(4);
      ulp(0);
      wr(2, u(0), 8'ha0);
      wr(3, 18'h00120 + 18'(w), 8'h3c ^ 8'(w));
      rd(18'h00120 + 18'(w));
      `CHK_EQ("prog_rd", 16'h5a3c ^ 16'(w), got)
    end
  endtask

  task automatic t_autosel();
    run(FIS_OP_AUTOSEL, 18'h0, 16'h0, 1'b0);
    nwr(3);
    wr(2, u(0), 8'h90);
    rd(18'h00000);
    `CHK_EQ("maker", flash.MAKER_ID, got)
    rd(18'h00001);
    `CHK_EQ("device", flash.DEV_ID, got)
    rd(18'h05002);
    `CHK_EQ("prot", 16'h0001, got)
    rd(18'h06002);
    `CHK_EQ("unprot", 16'h0000, got)
    rd(18'h00000);
    `CHK_EQ("maker_again", flash.MAKER_ID, got)
    run(FIS_OP_RESET, 18'h0, 16'h0, 1'b0);
    nwr(3);
    wr(2, u(0), 8'hf0);
    rd(18'h00000);
    `CHK_EQ("array", 16'hffff, got)
    run(FIS_OP_RESET, 18'h0, 16'h0, 1'b1);
    nwr(1);
    `CHK_EQ("short", 8'hf0, flash.wd[0][7:0])
    `CHK_EQ("no_wait", 1'b1, lat < 13)
  endtask

  task automatic t_erase();
    word_mode = 1'b0;
    run(FIS_OP_PROGRAM, 18'h03010, 16'h1234, 1'b0);
    run(FIS_OP_BLOCK_ERASE, 18'h03000, 16'h0, 1'b0);
    nwr(6);
    ulp(0);
    wr(2, u(0), 8'h80);
    ulp(3);
    wr(5, 18'h03000, 8'h30);
    rd(18'h03010);
    `CHK_EQ("blk_erased", 16'hffff, got)
    rd(18'h00120);
    `CHK_EQ("other_blk", 16'h5a3c, got)
    run(FIS_OP_ADD_BLOCK, 18'h04000, 16'h0, 1'b0);
    nwr(1);
    wr(0, 18'h04000, 8'h30);
    `CHK_EQ("late_add", 1'b1, op_timeout_hit)
    run(FIS_OP_CHIP_ERASE, 18'h0, 16'h0, 1'b0);
    nwr(6);
    wr(2, u(0), 8'h80);
    ulp(3);
    wr(5, u(0), 8'h10);
    rd(18'h00120);
    `CHK_EQ("chip_erased", 16'hffff, got)
  endtask

  task automatic t_suspend();
    run(FIS_OP_SUSPEND, 18'h2, 16'h0, 1'b0);
    nwr(1);
    `CHK_EQ("suspend", 8'hb0, flash.wd[0][7:0])
    run(FIS_OP_RESUME, 18'h2, 16'h0, 1'b0);
    nwr(1);
    `CHK_EQ("resume", 8'h30, flash.wd[0][7:0])
  endtask

  task automatic t_error();
    flash.err_inj = 1'b1;
    run(FIS_OP_PROGRAM, 18'h00200, 16'h0f0f, 1'b0);
    `CHK_EQ("op_error", 1'b1, op_error)
    flash.err_inj = 1'b0;
    run(FIS_OP_RESET, 18'h0, 16'h0, 1'b1);
    `CHK_EQ("recover", 1'b1, lat >= 13)
    `CHK_EQ("err_clr", 1'b0, op_error)
  endtask

  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    rd_valid = 1'b0;
    cmd_op = FIS_OP_RESET;
    cmd_short_reset = 1'b0;
    word_mode = 1'b0;
    cmd_addr = 18'h0;
    cmd_data = 16'h0;
    rd_addr = 18'h0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    t_reset();
    t_program();
    t_autosel();
    t_erase();
    t_suspend();
    t_error();
    test_done();
  end
endmodule
